// file: sas_defs.vh
// Constants shared by the converter sequencer files.
// Assumes inclusion by bare name from the same folder.
`ifndef SAS_DEFS_VH
`define SAS_DEFS_VH

// ****************************************
// Result and field widths
// ****************************************
`define SAS_RES_W 10
`define SAS_CHS_W 3
`define SAS_CLK_W 3
`define SAS_RES_MSB 9

// ****************************************
// Conversion timing
// ****************************************
`define SAS_NUM_PERIODS 4'hB
`define SAS_CNT_ZERO 4'h0
`define SAS_DIV_ZERO 6'h00
`define SAS_RC_SEL 2'h3

// ****************************************
// Conversion clock selects and divider limits
// ****************************************
`define SAS_SEL_DIV2 3'h0
`define SAS_SEL_DIV4 3'h4
`define SAS_SEL_DIV8 3'h1
`define SAS_SEL_DIV16 3'h5
`define SAS_SEL_DIV32 3'h2
`define SAS_SEL_DIV64 3'h6
`define SAS_LIM_DIV2 6'h01
`define SAS_LIM_DIV4 6'h03
`define SAS_LIM_DIV8 6'h07
`define SAS_LIM_DIV16 6'h0F
`define SAS_LIM_DIV32 6'h1F
`define SAS_LIM_DIV64 6'h3F

// ****************************************
// Reset values
// ****************************************
`define SAS_RES_RESET 10'h000
`define SAS_BYTE_ZERO 8'h00
`define SAS_CHS_ZERO 3'h0
`define SAS_PAD_ZERO 6'h00

`endif

// file: sas_tick_gen.v
// Bit-period tick generator for the converter sequencer.
// Assumes one system clock; the internal RC clock arrives as a pin.
`timescale 1ns/1ps
`default_nettype none

`include "sas_defs.vh"

module sas_tick_gen
(
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Control
    input wire run,
    input wire [2:0] clk_sel,
    input wire rc_clk_pin,
    // Tick out
    output reg tick
);

    reg [5:0] div_reg;
    reg [5:0] div_next;
    reg rc_meta_reg;
    reg rc_sync_reg;
    reg rc_last_reg;
    reg [5:0] limit;
    wire rc_mode;

    assign rc_mode = (clk_sel[1:0] == `SAS_RC_SEL);

    // Divider limit from select: 000/2 100/4 001/8 101/16 010/32 110/64
    always @*
    begin
        case (clk_sel)
            `SAS_SEL_DIV2: limit = `SAS_LIM_DIV2;
            `SAS_SEL_DIV4: limit = `SAS_LIM_DIV4;
            `SAS_SEL_DIV8: limit = `SAS_LIM_DIV8;
            `SAS_SEL_DIV16: limit = `SAS_LIM_DIV16;
            `SAS_SEL_DIV32: limit = `SAS_LIM_DIV32;
            `SAS_SEL_DIV64: limit = `SAS_LIM_DIV64;
            default: limit = `SAS_LIM_DIV2;
        endcase
    end

    // Divider next value, restarts each conversion
    always @*
    begin
        if (!run || div_reg == limit)
            div_next = `SAS_DIV_ZERO;
        else
            div_next = div_reg + 6'h01;
    end

    // Divider and RC synchroniser
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            div_reg <= `SAS_DIV_ZERO;
            rc_meta_reg <= 1'b0;
            rc_sync_reg <= 1'b0;
            rc_last_reg <= 1'b0;
            tick <= 1'b0;
        end
        else
        begin
            div_reg <= div_next;
            rc_meta_reg <= rc_clk_pin;
            rc_sync_reg <= rc_meta_reg;
            rc_last_reg <= rc_sync_reg;
            // RC period is independent of the system divider
            if (rc_mode)
                tick <= run && rc_sync_reg && !rc_last_reg;
            else
                tick <= run && (div_reg == limit);
        end
    end

endmodule // sas_tick_gen

`default_nettype wire

// file: sas_sequencer.v
// Successive-approximation converter sequencer, top level.
// Assumes the analog core compares on COMP_IN when TRIAL is presented,
// and software drives the control ports on CLK.
// Behaviour
// - Ten-bit approximation result stored at completion
// - Route one selected channel to hold
// - Reference bit picks supply or pin
// - Clock select chooses divider or RC
// - One sampling period, then one bit per period; eleven periods
// - Divided clocks follow system; RC independent
// - Done flag set at every completion
// - Done flag holds until software clears
// - Interrupt needs done flag and enable
// - Enabled completion in Sleep wakes device
// - Wake runs next instruction, vector if global
// - Justify bit selects left or right
// - Result registers read-only to software
`timescale 1ns/1ps
`default_nettype none

`include "sas_defs.vh"

module sas_sequencer
(
    // Clock and reset
    input wire CLK,
    input wire NRST,
    // Control from software
    input wire GO_SET,
    input wire [2:0] CHANNEL_SELECT,
    input wire POSITIVE_REFERENCE_SELECT,
    input wire [2:0] CONVERSION_CLOCK_SELECT,
    input wire RESULT_JUSTIFY_SELECT,
    input wire DONE_FLAG_CLEAR,
    input wire DONE_IRQ_ENABLE,
    input wire GLOBAL_IRQ_ENABLE,
    input wire SLEEPING,
    // Analog core side
    input wire COMP_IN,
    input wire INTERNAL_RC_CONV_CLOCK,
    // Analog core controls
    output reg [2:0] MUX_SELECT,
    output reg HOLD_CONNECT,
    output reg REF_PIN_SELECT,
    output reg [9:0] TRIAL,
    // Status to software
    output reg GO_BUSY,
    output reg CONVERSION_DONE_FLAG,
    output reg IRQ_REQUEST,
    output reg WAKE_REQUEST,
    output reg VECTOR_AFTER_WAKE,
    output reg [7:0] RESULT_HIGH_BYTE,
    output reg [7:0] RESULT_LOW_BYTE
);

    // ****************************************
    // States
    // ****************************************
    localparam ST_IDLE = 2'b01;
    localparam ST_CONV = 2'b10;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [3:0] period_reg;
    reg [3:0] period_next;
    reg [9:0] sar_reg;
    reg [9:0] sar_next;
    reg [9:0] bit_reg;
    reg [9:0] bit_next;
    reg comp_sync_reg;
    reg finish;
    reg done_flag_next;
    wire tick;

    // ****************************************
    // Functions
    // ****************************************

    // State decode shared by tick enable, hold switch and busy
    function in_conversion;
        input [1:0] state_code;
        begin
            in_conversion = (state_code == ST_CONV);
        end
    endfunction

    // Place the result left or right across the two bytes
    function [15:0] place_result;
        input right_just;
        input [9:0] value;
        begin
            if (right_just)
                place_result = {`SAS_PAD_ZERO, value};
            else
                place_result = {value, `SAS_PAD_ZERO};
        end
    endfunction

    // A completion request needs the flag and its enable
    function gate_request;
        input flag_value;
        input enable;
        begin
            gate_request = flag_value && enable;
        end
    endfunction

    // ****************************************
    // Bit-period tick
    // ****************************************
    sas_tick_gen u_tick
    (
        .clk(CLK),
        .nrst(NRST),
        .run(in_conversion(state_reg)),
        .clk_sel(CONVERSION_CLOCK_SELECT),
        .rc_clk_pin(INTERNAL_RC_CONV_CLOCK),
        .tick(tick)
    );

    // ****************************************
    // Comparator sample
    // ****************************************

    // The comparator answers TRIAL, which is launched on CLK, so one
    // stage suffices; a two-stage synchroniser would decide on the
    // previous trial code at the divide-by-two bit period.
    always @(posedge CLK)
    begin
        if (!NRST)
            comp_sync_reg <= 1'b0;
        else
            comp_sync_reg <= COMP_IN;
    end

    // ****************************************
    // Sequencer next state
    // ****************************************
    always @*
    begin
        state_next = state_reg;
        period_next = period_reg;
        sar_next = sar_reg;
        bit_next = bit_reg;
        finish = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (GO_SET)
                begin
                    state_next = ST_CONV;
                    period_next = `SAS_CNT_ZERO;
                    sar_next = `SAS_RES_RESET;
                    bit_next = {1'b1, 9'h000};
                end
            end
            ST_CONV:
            begin
                if (tick)
                begin
                    period_next = period_reg + 4'h1;
                    // First period samples; then one bit each
                    if (period_reg != `SAS_CNT_ZERO)
                    begin
                        if (comp_sync_reg)
                            sar_next = sar_reg | bit_reg;
                        bit_next = bit_reg >> 1;
                    end
                    if (period_next == `SAS_NUM_PERIODS)
                    begin
                        finish = 1'b1;
                        state_next = ST_IDLE;
                    end
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Registers and outputs
    // ****************************************

    // Done flag as it stands after this edge; set wins over clear
    always @*
    begin
        if (finish)
            done_flag_next = 1'b1;
        else if (DONE_FLAG_CLEAR)
            done_flag_next = 1'b0;
        else
            done_flag_next = CONVERSION_DONE_FLAG;
    end

    // ****************************************
    // Sequencer registers
    // ****************************************

    // State, period count, approximation and trial bit
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            state_reg <= ST_IDLE;
            period_reg <= `SAS_CNT_ZERO;
            sar_reg <= `SAS_RES_RESET;
            bit_reg <= `SAS_RES_RESET;
        end
        else
        begin
            state_reg <= state_next;
            period_reg <= period_next;
            sar_reg <= sar_next;
            bit_reg <= bit_next;
        end
    end

    // ****************************************
    // Analog core controls
    // ****************************************

    // Channel, reference, trial code and hold switch
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            MUX_SELECT <= `SAS_CHS_ZERO;
            HOLD_CONNECT <= 1'b1;
            REF_PIN_SELECT <= 1'b0;
            TRIAL <= `SAS_RES_RESET;
        end
        else
        begin
            MUX_SELECT <= CHANNEL_SELECT;
            REF_PIN_SELECT <= POSITIVE_REFERENCE_SELECT;
            TRIAL <= sar_next | bit_next;
            // Hold opens after the sampling period, recloses at end
            if (finish)
                HOLD_CONNECT <= 1'b1;
            else if (in_conversion(state_reg) && tick)
                HOLD_CONNECT <= 1'b0;
        end
    end

    // ****************************************
    // Status to software
    // ****************************************

    // Busy, done flag and the requests that follow the flag
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            GO_BUSY <= 1'b0;
            CONVERSION_DONE_FLAG <= 1'b0;
            IRQ_REQUEST <= 1'b0;
            WAKE_REQUEST <= 1'b0;
            VECTOR_AFTER_WAKE <= 1'b0;
        end
        else
        begin
            GO_BUSY <= in_conversion(state_next);
            CONVERSION_DONE_FLAG <= done_flag_next;
            // Requests follow the flag as it stands, so a clear drops them
            IRQ_REQUEST <= gate_request(done_flag_next,
                DONE_IRQ_ENABLE);
            WAKE_REQUEST <= SLEEPING
                && gate_request(done_flag_next, DONE_IRQ_ENABLE);
            VECTOR_AFTER_WAKE <= SLEEPING && GLOBAL_IRQ_ENABLE
                && gate_request(done_flag_next, DONE_IRQ_ENABLE);
        end
    end

    // ****************************************
    // Result bytes
    // ****************************************

    // Only path that changes result bytes
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            RESULT_HIGH_BYTE <= `SAS_BYTE_ZERO;
            RESULT_LOW_BYTE <= `SAS_BYTE_ZERO;
        end
        else if (finish)
        begin
            {RESULT_HIGH_BYTE, RESULT_LOW_BYTE} <=
                place_result(RESULT_JUSTIFY_SELECT, sar_next);
        end
    end

endmodule // sas_sequencer

`default_nettype wire

// file: sas_core_model.sv
// Analog core model: channel mux, hold capacitor, comparator.
// Assumes the sequencer drives the analog controls from CLK.
`timescale 1ns/1ps
`default_nettype none
module sas_core_model
(
    // Analog controls
    input wire logic [2:0] mux_sel,
    input wire logic hold,
    input wire logic [9:0] trial,
    // Comparator out
    output logic comp
);
    logic [9:0] held;
    // Sample the selected channel while the capacitor is connected
    always @*
        if (hold)
            held = {mux_sel, 7'h2B};
    // Held level at or above trial keeps the bit
    assign comp = held >= trial;
endmodule // sas_core_model
`default_nettype wire

// file: sas_checker_assertions.sv
// Port checker for the converter sequencer.
// Assumes the sequencer top ports, bound below.
`timescale 1ns/1ps
`default_nettype none
module sas_checker
(
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Inputs seen
    input wire logic GO_SET,
    input wire logic [2:0] CHANNEL_SELECT,
    input wire logic RESULT_JUSTIFY_SELECT,
    input wire logic DONE_FLAG_CLEAR,
    input wire logic DONE_IRQ_ENABLE,
    input wire logic SLEEPING,
    // Outputs watched
    input wire logic [2:0] MUX_SELECT,
    input wire logic HOLD_CONNECT,
    input wire logic GO_BUSY,
    input wire logic CONVERSION_DONE_FLAG,
    input wire logic IRQ_REQUEST,
    input wire logic WAKE_REQUEST,
    input wire logic [7:0] RESULT_HIGH_BYTE,
    input wire logic [7:0] RESULT_LOW_BYTE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    go_accept_a:
        assert property (GO_SET && !GO_BUSY |=> GO_BUSY)
        else $error("start not taken");
    done_sets_a:
        assert property ($fell(GO_BUSY) |-> CONVERSION_DONE_FLAG
            && HOLD_CONNECT) else $error("completion incomplete");
    flag_hold_a:
        assert property (CONVERSION_DONE_FLAG && !DONE_FLAG_CLEAR
            |=> CONVERSION_DONE_FLAG) else $error("flag dropped");
    irq_gate_a:
        assert property (IRQ_REQUEST == (CONVERSION_DONE_FLAG
            && $past(DONE_IRQ_ENABLE))) else $error("irq wrong");
    wake_gate_a:
        assert property (WAKE_REQUEST == (CONVERSION_DONE_FLAG
            && $past(SLEEPING && DONE_IRQ_ENABLE)))
        else $error("wake wrong");
    result_load_a:
        assert property ($changed({RESULT_HIGH_BYTE, RESULT_LOW_BYTE})
            |-> $fell(GO_BUSY)) else $error("result moved");
    hold_open_a:
        assert property ($fell(HOLD_CONNECT) |-> GO_BUSY)
        else $error("hold opened idle");
    mux_follow_a:
        assert property (NRST |=> MUX_SELECT == $past(CHANNEL_SELECT))
        else $error("mux lag wrong");
    left_pad_a:
        assert property ($fell(GO_BUSY) && !$past(RESULT_JUSTIFY_SELECT)
            |-> RESULT_LOW_BYTE[5:0] == 6'h00) else $error("pad wrong");
    busy_span_a:
        assert property ($rose(GO_BUSY) |-> ##[1:800] !GO_BUSY)
        else $error("conversion hung");
    cover property ($fell(GO_BUSY));
    cover property (WAKE_REQUEST);
    cover property (CONVERSION_DONE_FLAG && DONE_FLAG_CLEAR);
endmodule // sas_checker
bind sas_sequencer sas_checker u_chk (.CLK(CLK), .NRST(NRST),
    .GO_SET(GO_SET), .CHANNEL_SELECT(CHANNEL_SELECT),
    .RESULT_JUSTIFY_SELECT(RESULT_JUSTIFY_SELECT),
    .DONE_FLAG_CLEAR(DONE_FLAG_CLEAR), .DONE_IRQ_ENABLE(DONE_IRQ_ENABLE),
    .SLEEPING(SLEEPING), .MUX_SELECT(MUX_SELECT),
    .HOLD_CONNECT(HOLD_CONNECT), .GO_BUSY(GO_BUSY),
    .CONVERSION_DONE_FLAG(CONVERSION_DONE_FLAG),
    .IRQ_REQUEST(IRQ_REQUEST), .WAKE_REQUEST(WAKE_REQUEST),
    .RESULT_HIGH_BYTE(RESULT_HIGH_BYTE), .RESULT_LOW_BYTE(RESULT_LOW_BYTE));
`default_nettype wire

// file: sas_sequencer_tb.sv
// Self-checking bench for the converter sequencer.
// Assumes the core model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer_tb;
    logic clk = 0, nrst = 0, go = 0, clr = 0, rc = 0, comp;
    logic [2:0] ch = 0, cks = 0;
    logic rs = 0, just = 0, ien = 0, global_irq_enable = 0, slp = 0;
    logic [2:0] mux;
    logic hold, refo, busy, flag, irq, wake, vec;
    logic [9:0] trial;
    logic [7:0] hi, lo;
    int mismatches = 0, n_tests = 0;
    sas_sequencer DUT (.CLK(clk), .NRST(nrst), .GO_SET(go),
        .CHANNEL_SELECT(ch), .POSITIVE_REFERENCE_SELECT(rs),
        .CONVERSION_CLOCK_SELECT(cks), .RESULT_JUSTIFY_SELECT(just),
        .DONE_FLAG_CLEAR(clr), .DONE_IRQ_ENABLE(ien),
        .GLOBAL_IRQ_ENABLE(global_irq_enable), .SLEEPING(slp), .COMP_IN(comp),
        .INTERNAL_RC_CONV_CLOCK(rc), .MUX_SELECT(mux),
        .HOLD_CONNECT(hold), .REF_PIN_SELECT(refo), .TRIAL(trial),
        .GO_BUSY(busy), .CONVERSION_DONE_FLAG(flag), .IRQ_REQUEST(irq),
        .WAKE_REQUEST(wake), .VECTOR_AFTER_WAKE(vec),
        .RESULT_HIGH_BYTE(hi), .RESULT_LOW_BYTE(lo));
    sas_core_model u_core (.mux_sel(mux), .hold(hold), .trial(trial),
        .comp(comp));
    // System clock and free RC clock
    initial
    begin
        forever #20 clk = ~clk;
    end
    always #45 rc = ~rc;
    // Count and report one comparison
    task automatic check(input string what, input logic [15:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", what, e, g);
        end
    endtask
    // Verdict and end of run
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One conversion with clock select k on channel k
    task automatic convert(input logic [2:0] k);
        logic [9:0] r;
        int n, lo_n, hi_n;
        r = {k, 7'h2B};
        case (k)
            0: lo_n = 22;
            4: lo_n = 44;
            1: lo_n = 88;
            5: lo_n = 176;
            2: lo_n = 352;
            6: lo_n = 704;
            default: lo_n = 15;
        endcase
        hi_n = (k[1:0] == 2'h3) ? 45 : lo_n + 6;
        ch = k;
        cks = k;
        just = k[0];
        rs = k[1];
        ien = k[0];
        global_irq_enable = k[2];
        slp = k[1:0] == 2'h3;
        repeat (4) @(negedge clk);
        go = 1;
        repeat (3) @(negedge clk);
        go = 0;
        check("refused", 1, busy);
        n = 3;
        while (busy && n < 900)
        begin
            @(negedge clk);
            n++;
        end
        check("period", 1, n >= lo_n && n <= hi_n);
        check("flag", 1, flag);
        check("ref", rs, refo);
        if (just)
            check("result", {6'h00, r}, {hi, lo});
        else
            check("result", {r, 6'h00}, {hi, lo});
        @(negedge clk);
        check("irq", ien, irq);
        check("wake", slp && ien, wake);
        if (slp && ien)
            check("vector", global_irq_enable, vec);
        clr = 1;
        @(negedge clk);
        clr = 0;
        @(negedge clk);
        check("cleared", 0, {flag, irq});
    endtask
    // Reset, then every clock select
    initial
    begin
        repeat (6) @(negedge clk);
        nrst = 1;
        check("idle", 3'h4, {hold, flag, busy});
        for (int k = 0; k < 8; k++)
            convert(k[2:0]);
        complete_run();
    end
    // Watchdog
    initial
    begin
        #400000;
        mismatches++;
        complete_run();
    end
endmodule // sas_sequencer_tb
`default_nettype wire
